// ### rtl/bit_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a slow level or toggle
// Notes:   first flop feeds only the second
module bit_sync
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // level in and out
   input  wire logic din,
   output logic      dout
);
   logic meta; // first stage, read only below

   // two stages, cleared by reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

// ### rtl/error_report_unload_and_inject.sv
// Purpose: report unload and fault injection of an error detector
// Assumes: engine and fabric logic share core_clk; tck is separate
// Notes:   detection clock is a divided tick of core_clk
//
// Behaviour
// - Report copied into user update register
// - Unload instruction puts report in scan path
// - Report layout: syndrome, frame, byte, bit, type
// - Inject instruction selects 21-bit control register
// - All-zero control word disables injection
// - Type decode: none, single, double-adjacent, invalid
// - Invert located bits in first frame only
// - Single and double-adjacent errors supported
// - shiftnld high shifts, low parallel loads
// - Serial output one bit, lsb first
// - Flag low 32 ticks, rises after update
// - Control word: type, byte location, byte value
`include "error_report_map.svh"
module error_report_unload_and_inject
#(
   parameter int DET_DIV = `DET_DIVIDER // core clocks per detection tick
)
(
   // clocks and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire logic                        tck,
   // fabric unload port
   input  wire logic                        shiftnld,
   output logic                             regout,
   // detection engine
   input  wire logic                        calc_start,
   input  wire logic                        report_valid,
   input  wire error_report_pkg::emr_t      report,
   output logic                             check_fail,
   // test access
   input  wire logic [`INSTR_WIDTH-1:0]     instr,
   input  wire error_report_pkg::tap_ctrl_t tap,
   input  wire logic                        tdi,
   output logic                             tdo,
   output logic                             tdo_enable,
   // readback stream
   input  wire logic                        rb_in_valid,
   input  wire error_report_pkg::rb_byte_t  rb_in,
   output logic                             rb_out_valid,
   output error_report_pkg::rb_byte_t       rb_out,
   output error_report_pkg::inject_kind_t   inject_kind
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [7:0]                     det_cnt;   // tick divider
   logic                           det_tick;  // detection clock tick
   error_report_pkg::emr_t         error_message_report;       // message report
   logic                           emr_tg;    // report written toggle
   error_report_pkg::emr_t         update;    // user update register
   logic [1:0]                     hold_cnt;  // ticks with shiftnld low
   logic                           upd_en;    // update copy enable
   logic [`EMR_WIDTH-1:0]          user_shift;// user shift register
   error_report_pkg::check_state_t chk_state; // check sequencer
   logic [5:0]                     chk_cnt;   // ticks in calculation
   logic                           err_pend;  // error seen this calc
   error_report_pkg::fir_t         fir_word;  // word from scan side
   logic                           fir_tg;    // word written toggle
   logic                           fir_tg_s;  // synced toggle
   logic                           fir_tg_d;  // previous toggle
   error_report_pkg::fir_t         fir_core;  // active control word

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // two-bit type code to injection kind
   function automatic error_report_pkg::inject_kind_t decode_kind
      (input logic [`FIR_TYPE_W-1:0] t);
      logic [3:0] code;
      code = {2'b00, t};
      case (code)
         `INJ_CODE_NONE:   decode_kind = error_report_pkg::INJ_NONE;
         `INJ_CODE_SINGLE: decode_kind = error_report_pkg::INJ_SINGLE;
         `INJ_CODE_DOUBLE: decode_kind = error_report_pkg::INJ_DOUBLE_ADJ;
         default:          decode_kind = error_report_pkg::INJ_INVALID;
      endcase
   endfunction

   // bits to invert in one readback byte
   function automatic logic [`FIR_VALUE_W-1:0] flip_mask
      (input error_report_pkg::fir_t f,
       input logic [`FIR_BYTE_W-1:0] idx);
      logic [`FIR_BYTE_W-1:0] nxt;
      nxt = f.byte_loc + 11'h001;
      flip_mask = '0;
      case (decode_kind(f.err_type))
         error_report_pkg::INJ_SINGLE:
            if (idx == f.byte_loc)
               flip_mask = f.err_value;
         error_report_pkg::INJ_DOUBLE_ADJ:
            if (idx == f.byte_loc || idx == nxt)
               flip_mask = f.err_value;
         default:
            flip_mask = '0;
      endcase
   endfunction

   // ----------------------------------------
   // detection clock tick
   // ----------------------------------------
   assign det_tick = (det_cnt == 8'(DET_DIV - 1));

   // free-running divider
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         det_cnt <= 8'h00;
      else if (det_tick)
         det_cnt <= 8'h00;
      else
         det_cnt <= det_cnt + 8'h01;
   end

   // ----------------------------------------
   // message report and update register
   // ----------------------------------------
   // engine writes the report, toggle tells scan side
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         error_message_report    <= `EMR_RESET;
         emr_tg <= 1'b0;
      end
      else if (report_valid)
      begin
         error_message_report    <= report;
         emr_tg <= ~emr_tg;
      end
   end

   // count ticks of shiftnld low, copy frozen after two
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         hold_cnt <= 2'h0;
      else if (shiftnld)
         hold_cnt <= 2'h0;
      else if (det_tick && hold_cnt != `LOAD_WAIT_TICKS)
         hold_cnt <= hold_cnt + 2'h1;
   end

   assign upd_en = (hold_cnt != `LOAD_WAIT_TICKS);

   // update follows the report one cycle later
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         update <= `EMR_RESET;
      else if (upd_en)
         update <= error_message_report;
   end

   // ----------------------------------------
   // user shift register
   // ----------------------------------------
   // load when low, shift lsb first when high
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         user_shift <= `EMR_RESET;
      else if (shiftnld)
         user_shift <= {1'b0, user_shift[`EMR_WIDTH-1:1]};
      else
         user_shift <= update;
   end

   assign regout = user_shift[0];

   // ----------------------------------------
   // check-fail sequencer
   // ----------------------------------------
   // ticks since the calculation began, saturating
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         chk_cnt <= 6'h00;
      else if (calc_start)
         chk_cnt <= 6'h00;
      else if (det_tick && chk_cnt != `CHECK_LOW_CYCLES)
         chk_cnt <= chk_cnt + 6'h01;
   end

   // error seen; a new report beats the clear
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         err_pend <= 1'b0;
      else if (report_valid)
         err_pend <= 1'b1;
      else if (calc_start)
         err_pend <= 1'b0;
   end

   // flag low through the calc, high once both hold
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         chk_state  <= error_report_pkg::CHK_IDLE;
         check_fail <= 1'b0;
      end
      else
      begin
         case (chk_state)
            error_report_pkg::CHK_CALC:
               if (calc_start)
                  check_fail <= 1'b0;
               else if (chk_cnt == `CHECK_LOW_CYCLES && err_pend)
               begin
                  chk_state  <= error_report_pkg::CHK_FLAG;
                  check_fail <= 1'b1;
               end
            error_report_pkg::CHK_FLAG:
               if (calc_start)
               begin
                  chk_state  <= error_report_pkg::CHK_CALC;
                  check_fail <= 1'b0;
               end
            default:
               if (calc_start)
               begin
                  chk_state  <= error_report_pkg::CHK_CALC;
                  check_fail <= 1'b0;
               end
         endcase
      end
   end

   // ----------------------------------------
   // scan side and injection word crossing
   // ----------------------------------------
   report_scan_port u_scan
   (
      .tck        (tck),
      .rst        (rst),
      .instr      (instr),
      .tap        (tap),
      .tdi        (tdi),
      .tdo        (tdo),
      .tdo_enable (tdo_enable),
      .emr_word   (error_message_report),
      .emr_toggle (emr_tg),
      .fir_word   (fir_word),
      .fir_toggle (fir_tg)
   );

   bit_sync u_fir_sync
   (
      .clk  (core_clk),
      .rst  (rst),
      .din  (fir_tg),
      .dout (fir_tg_s)
   );

   // adopt a new word; zero disables injection
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         fir_tg_d <= 1'b0;
         fir_core <= `FIR_RESET;
      end
      else
      begin
         fir_tg_d <= fir_tg_s;
         if (fir_tg_s != fir_tg_d)
            fir_core <= fir_word;
      end
   end

   // ----------------------------------------
   // readback injection
   // ----------------------------------------
   // invert chosen bits in the first frame only
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rb_out_valid <= 1'b0;
         rb_out       <= '0;
         inject_kind  <= error_report_pkg::INJ_NONE;
      end
      else
      begin
         rb_out_valid <= rb_in_valid;
         inject_kind  <= decode_kind(fir_core.err_type);
         rb_out       <= rb_in;
         if (rb_in_valid && rb_in.first_frame)
            rb_out.data <= rb_in.data ^ flip_mask(fir_core, rb_in.byte_idx);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_UPDATE_FOLLOWS: assert property (
      report_valid ##1 upd_en |=> update == $past(report, 2))
      else $error("update register missed the new report");
   AST_FREEZE_HOLDS: assert property (
      !shiftnld && !upd_en |=> $stable(update))
      else $error("update register changed while frozen");
   AST_PARALLEL_LOAD: assert property (
      !shiftnld |=> user_shift == $past(update))
      else $error("shift register not loaded from update");
   AST_LSB_FIRST: assert property (
      shiftnld |=> regout == $past(user_shift[1]))
      else $error("serial output not lsb first");
   AST_FLAG_RISE: assert property (
      $rose(check_fail) |-> $past(chk_cnt) == 6'h20 && $past(err_pend))
      else $error("check flag rose too early");
   AST_FLAG_LOW: assert property (
      calc_start |=> !check_fail [*2])
      else $error("check flag not low at calculation start");
   AST_ZERO_NO_FLIP: assert property (
      rb_in_valid && fir_core == '0 |=> rb_out.data == $past(rb_in.data))
      else $error("zero control word still flips bits");
   AST_OTHER_FRAME: assert property (
      rb_in_valid && !rb_in.first_frame
      |=> rb_out.data == $past(rb_in.data))
      else $error("bits flipped outside the first frame");
   AST_SINGLE_FLIP: assert property (
      rb_in_valid && rb_in.first_frame && fir_core.err_type == 2'b01
      && rb_in.byte_idx == fir_core.byte_loc
      |=> rb_out.data == $past(rb_in.data ^ fir_core.err_value))
      else $error("single injection not applied at location");
   AST_ADJ_FLIP: assert property (
      rb_in_valid && rb_in.first_frame && fir_core.err_type == 2'b10
      && rb_in.byte_idx == fir_core.byte_loc + 11'h001
      |=> rb_out.data == $past(rb_in.data ^ fir_core.err_value))
      else $error("adjacent byte not flipped");
   AST_INVALID_TYPE: assert property (
      rb_in_valid && fir_core.err_type == 2'b11
      |=> rb_out.data == $past(rb_in.data))
      else $error("invalid type injected an error");

   COV_FLAG: cover property ($rose(check_fail));
   COV_UNLOAD: cover property (!shiftnld ##1 shiftnld [*8]);
   COV_INJECT: cover property (rb_out_valid && rb_out.data != $past(rb_in.data));
endmodule

// ### rtl/report_scan_port.sv
// Purpose: scan side of the report block, on the test clock
// Assumes: tap controller outside gives instruction and strobes
// Notes:   words cross by toggle plus stable data
`include "error_report_map.svh"
module report_scan_port
(
   // test clock and reset
   input  wire logic                      tck,
   input  wire logic                      rst,
   // tap side
   input  wire logic [`INSTR_WIDTH-1:0]   instr,
   input  wire error_report_pkg::tap_ctrl_t tap,
   input  wire logic                      tdi,
   output logic                           tdo,
   output logic                           tdo_enable,
   // core side crossing
   input  wire error_report_pkg::emr_t    emr_word,
   input  wire logic                      emr_toggle,
   output error_report_pkg::fir_t         fir_word,
   output logic                           fir_toggle
);
   logic [1:0]               rst_pipe;  // local reset release
   logic                     rst_tck;   // synchronised reset
   logic                     emr_tg_s;  // synced report toggle
   logic                     emr_tg_d;  // previous toggle
   error_report_pkg::emr_t   emr_snap;  // local report copy
   logic [`EMR_WIDTH-1:0]    dr;        // scan data register
   logic                     sel_msg;   // unload selected
   logic                     sel_fir;   // inject selected

   assign sel_msg = (instr == `INSTR_MSG_UNLOAD);
   assign sel_fir = (instr == `INSTR_FAULT_INJECT);
   assign rst_tck = rst_pipe[1];
   assign tdo     = dr[0];

   // reset release aligned to the test clock
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
         rst_pipe <= 2'b11;
      else
         rst_pipe <= {rst_pipe[0], 1'b0};
   end

   bit_sync u_emr_sync
   (
      .clk  (tck),
      .rst  (rst_tck),
      .din  (emr_toggle),
      .dout (emr_tg_s)
   );

   // take a fresh report copy on each toggle
   always_ff @(posedge tck or posedge rst_tck)
   begin
      if (rst_tck)
      begin
         emr_tg_d <= 1'b0;
         emr_snap <= `EMR_RESET;
      end
      else
      begin
         emr_tg_d <= emr_tg_s;
         if (emr_tg_s != emr_tg_d)
            emr_snap <= emr_word;
      end
   end

   // capture and shift of the selected register
   always_ff @(posedge tck or posedge rst_tck)
   begin
      if (rst_tck)
         dr <= `EMR_RESET;
      else if (tap.capture_dr && sel_msg)
         dr <= emr_snap;
      else if (tap.capture_dr && sel_fir)
         dr <= {{(`EMR_WIDTH-`FIR_WIDTH){1'b0}}, fir_word};
      else if (tap.shift_dr && sel_msg)
         dr <= {tdi, dr[`EMR_WIDTH-1:1]};
      else if (tap.shift_dr && sel_fir)
         dr <= {{(`EMR_WIDTH-`FIR_WIDTH){1'b0}}, tdi, dr[`FIR_WIDTH-1:1]};
   end

   // update writes the injection control word
   always_ff @(posedge tck or posedge rst_tck)
   begin
      if (rst_tck)
      begin
         fir_word   <= `FIR_RESET;
         fir_toggle <= 1'b0;
         tdo_enable <= 1'b0;
      end
      else
      begin
         tdo_enable <= tap.shift_dr && (sel_msg || sel_fir);
         if (tap.update_dr && sel_fir)
         begin
            fir_word   <= dr[`FIR_WIDTH-1:0];
            fir_toggle <= ~fir_toggle;
         end
      end
   end

   AST_UNLOAD_CAPTURE: assert property (@(posedge tck) disable iff (rst_tck)
      tap.capture_dr && sel_msg |=> dr == $past(emr_snap))
      else $error("scan path does not hold the report after capture");
   AST_FIR_UPDATE: assert property (@(posedge tck) disable iff (rst_tck)
      tap.update_dr && sel_fir && !tap.capture_dr
      |=> fir_word == $past(dr[`FIR_WIDTH-1:0]) ##1 $stable(fir_word))
      else $error("injection word not written from scan register");
endmodule

// ### shared/error_report_map.svh
// Purpose: offsets, field positions, codes and counts
// Assumes: included by the package and the design files
// Notes:   definitions only
`ifndef ERROR_REPORT_MAP_SVH
`define ERROR_REPORT_MAP_SVH
// ----------------------------------------
// error message report layout
// ----------------------------------------
`define EMR_WIDTH          46
`define EMR_SYND_W         16
`define EMR_FRAME_W        14
`define EMR_BYTE_W         11
`define EMR_BIT_W          3
`define EMR_TYPE_W         2
`define EMR_RESET          46'h0000_0000_0000
// ----------------------------------------
// fault injection control layout
// ----------------------------------------
`define FIR_WIDTH          21
`define FIR_TYPE_W         2
`define FIR_BYTE_W         11
`define FIR_VALUE_W        8
`define FIR_RESET          21'h00_0000
`define INJ_CODE_NONE      4'h0
`define INJ_CODE_SINGLE    4'h1
`define INJ_CODE_DOUBLE    4'h2
// ----------------------------------------
// scan instructions and timing counts
// ----------------------------------------
`define INSTR_WIDTH        10
`define INSTR_MSG_UNLOAD   10'h017
`define INSTR_FAULT_INJECT 10'h015
`define CHECK_LOW_CYCLES   6'h20
`define LOAD_WAIT_TICKS    2'h2
`define DET_DIVIDER        2
`endif

// ### shared/error_report_pkg.sv
// Purpose: shared types of the error report block
// Assumes: map header holds the field widths
// Notes:   carriers are packed structs
package error_report_pkg;
`include "error_report_map.svh"
   // scanned / unloaded message layout, msb first
   typedef struct packed {
      logic [`EMR_SYND_W-1:0]  syndrome;
      logic [`EMR_FRAME_W-1:0] frame_addr;
      logic [`EMR_BYTE_W-1:0]  byte_loc;
      logic [`EMR_BIT_W-1:0]   bit_loc;
      logic [`EMR_TYPE_W-1:0]  err_type;
   } emr_t;
   // fault injection control, msb first
   typedef struct packed {
      logic [`FIR_TYPE_W-1:0]  err_type;
      logic [`FIR_BYTE_W-1:0]  byte_loc;
      logic [`FIR_VALUE_W-1:0] err_value;
   } fir_t;
   // one readback byte of a frame
   typedef struct packed {
      logic                    first_frame;
      logic [`FIR_BYTE_W-1:0]  byte_idx;
      logic [`FIR_VALUE_W-1:0] data;
   } rb_byte_t;
   // tap data-register phase strobes
   typedef struct packed {
      logic capture_dr;
      logic shift_dr;
      logic update_dr;
   } tap_ctrl_t;
   typedef enum logic [1:0] {
      INJ_NONE       = 2'b00,
      INJ_SINGLE     = 2'b01,
      INJ_DOUBLE_ADJ = 2'b10,
      INJ_INVALID    = 2'b11
   } inject_kind_t;
   typedef enum logic [1:0] {
      CHK_IDLE = 2'b00,
      CHK_CALC = 2'b01,
      CHK_FLAG = 2'b10
   } check_state_t;
endpackage

// ### tb/testbench.sv
// Purpose: self-checking bench of the report block
// Assumes: tck runs free at 30 ns
// Notes:   random reports and injections, fixed seed
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 2; // detection divider
   logic core_clk, rst, tck, shiftnld, regout, calc_start;
   logic report_valid, check_fail, tdi, tdo, tdo_enable;
   logic rb_in_valid, rb_out_valid, done;
   logic [9:0]                     instr;
   logic [45:0]                    cap, sout;
   error_report_pkg::emr_t         report;
   error_report_pkg::tap_ctrl_t    tap;
   error_report_pkg::rb_byte_t     rb_in, rb_out;
   error_report_pkg::inject_kind_t inject_kind;
   error_report_pkg::fir_t         fir, fir_old;
   int n_fail, n_checks, cyc, k, j;
   error_report_unload_and_inject #(.DET_DIV(DIV)) i_error_report_unload_and_inject (
      .core_clk(core_clk), .rst(rst), .tck(tck), .shiftnld(shiftnld), .regout(regout),
      .calc_start(calc_start), .report_valid(report_valid), .report(report),
      .check_fail(check_fail), .instr(instr), .tap(tap), .tdi(tdi), .tdo(tdo),
      .tdo_enable(tdo_enable), .rb_in_valid(rb_in_valid), .rb_in(rb_in),
      .rb_out_valid(rb_out_valid), .rb_out(rb_out), .inject_kind(inject_kind));
   unload_ctrl_model #(.DET_DIV(DIV)) i_unload_ctrl_model (.core_clk(core_clk), .rst(rst),
      .trigger(check_fail), .regout(regout), .shiftnld(shiftnld), .data(cap), .done(done));
   // ----------------------------------------
   // clocks and timeout
   // ----------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial
   begin
      tck = 1'b0;
      #7;
      forever #15 tck = ~tck;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         test_done();
      end
   end
   // ----------------------------------------
   // compare and helper tasks
   // ----------------------------------------
   task automatic chk_word(logic [45:0] got, logic [45:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(logic got, logic exp);
      chk_word(46'(got), 46'(exp));
   endtask
   // expected readback byte after injection
   function automatic logic [7:0] exp_rb(error_report_pkg::fir_t f,
                                         error_report_pkg::rb_byte_t b);
      logic hit;
      hit = b.first_frame && ((f.err_type == 2'b01 && b.byte_idx == f.byte_loc) ||
            (f.err_type == 2'b10 && (b.byte_idx == f.byte_loc ||
             b.byte_idx == f.byte_loc + 11'h001)));
      return hit ? b.data ^ f.err_value : b.data;
   endfunction
   // one data-register scan, lsb first
   task automatic scan(logic [9:0] ins, int n, logic [45:0] din);
      int i;
      @(negedge tck) instr = ins;
      @(negedge tck) tap = 3'b100;
      for (i = 0; i < n; i++)
      begin
         @(negedge tck) sout[i] = tdo;
         if (i == 1) chk_flag(tdo_enable, 1'b1);
         tap = 3'b010;
         tdi = din[i];
      end
      @(negedge tck) tap = 3'b001;
      @(negedge tck) tap = 3'b000;
      chk_flag(tdo_enable, 1'b0);
   endtask
   // one calculation with an error, then fabric unload
   task automatic report_err();
      int t;
      @(negedge core_clk) calc_start = 1'b1;
      @(negedge core_clk) calc_start = 1'b0;
      report = 46'({$urandom(), $urandom()});
      report_valid = 1'b1;
      @(negedge core_clk) report_valid = 1'b0;
      chk_flag(check_fail, 1'b0);
      t = 2;
      while (check_fail !== 1'b1 && t < 400)
      begin
         @(negedge core_clk);
         t++;
      end
      chk_flag(check_fail === 1'b1 && t >= 32 * DIV, 1'b1);
      t = 0;
      while (done !== 1'b1 && t < 300)
      begin
         @(negedge core_clk);
         t++;
      end
      chk_word(cap, report);
   endtask
   // one readback byte through the injector
   task automatic rb_byte(int m);
      error_report_pkg::rb_byte_t b;
      b = {m != 3, fir.byte_loc + 11'(m % 3), 8'($urandom())};
      @(negedge core_clk) rb_in = b;
      rb_in_valid = 1'b1;
      @(negedge core_clk) rb_in_valid = 1'b0;
      chk_flag(rb_out_valid, 1'b1);
      chk_word(46'(rb_out), 46'({b.first_frame, b.byte_idx, exp_rb(fir, b)}));
   endtask
   task automatic test_done();
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {rst, calc_start, report_valid, tdi, rb_in_valid} = 5'b10000;
      {instr, tap, report, rb_in} = '0;
      void'($urandom(32'hdda9));
      repeat (5) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      chk_flag(check_fail, 1'b0);
      chk_word(46'(inject_kind), 46'h0);
      repeat (4) @(negedge core_clk);
      for (k = 0; k < 3; k++)
         report_err();
      $display("test unload done");
      scan(10'h017, 46, 46'h0);
      chk_word(sout, report);
      $display("test scan done");
      fir_old = '0;
      for (k = 0; k < 5; k++)
      begin
         fir = (k == 4) ? '0 : {2'(k), 11'($urandom()), 8'($urandom()) | 8'h01};
         scan(10'h015, 21, 46'(fir));
         chk_word(46'(sout[20:0]), 46'(fir_old));
         fir_old = fir;
         repeat (10) @(negedge core_clk);
         chk_word(46'(inject_kind), 46'(fir.err_type));
         for (j = 0; j < 4; j++)
            rb_byte(j);
      end
      $display("test inject done");
      test_done();
   end
endmodule

// ### tb/unload_ctrl_model.sv
// Purpose: fabric control logic that unloads the report
// Assumes: trigger is the check-fail flag
// Notes:   one unload per trigger rise
module unload_ctrl_model
#(
   parameter int DET_DIV = 2 // core clocks per detection tick
)
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // trigger and serial data
   input  wire logic        trigger,
   input  wire logic        regout,
   output logic             shiftnld,
   // captured report
   output logic [45:0]      data,
   output logic             done
);
   timeunit 1ns;
   timeprecision 1ps;
   // low time covers the freeze and the load edge
   localparam int LOW = 2 * DET_DIV + 2;
   logic [1:0] sync; // trigger synchroniser
   logic       prev; // last synced level
   logic       busy; // unload running
   logic [6:0] cnt;  // cycle count in unload
   // ----------------------------------------
   // trigger sync and edge detect
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         {prev, sync} <= 3'h0;
      else
         {prev, sync} <= {sync[1], sync[0], trigger};
   // ----------------------------------------
   // unload sequencer
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         busy     <= 1'b0;
         shiftnld <= 1'b1;
         cnt      <= 7'h00;
         done     <= 1'b0;
         data     <= 46'h0;
      end
      else
      begin
         done <= 1'b0;
         // start on a rise only
         if (!busy && sync[1] && !prev)
         begin
            busy     <= 1'b1;
            shiftnld <= 1'b0;
            cnt      <= 7'h00;
         end
         else if (busy)
         begin
            cnt <= cnt + 7'h01;
            // raise after the load edge
            if (cnt == 7'(LOW - 1))
               shiftnld <= 1'b1;
            // 30 location bits then 16 syndrome bits
            if (cnt >= 7'(LOW))
               data <= {regout, data[45:1]};
            // back to idle after 46 bits
            if (cnt == 7'(LOW + 45))
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule
